// ---- inc/txpmx_map.svh ----
// Register offsets, field positions and reset values of the transmit port selector.
`ifndef TXPMX_MAP_SVH
`define TXPMX_MAP_SVH
`define TXPMX_ADDR_W 8
`define TXPMX_OFS_PORT_A 8'h80
`define TXPMX_OFS_PORT_B 8'h81
`define TXPMX_OFS_PORT_C 8'h82
`define TXPMX_OFS_PORT_D 8'h83
`define TXPMX_OFS_POL_DIR 8'h84
`define TXPMX_OFS_STATUS 8'h85
`define TXPMX_RST_CFG 8'h00
`define TXPMX_FUNC_MSB 3
`define TXPMX_BIT_RX_CLK_DIR 0
`define TXPMX_BIT_SYS_RX_CLK_DIR 1
`define TXPMX_BIT_RSVD 2
`define TXPMX_BIT_MFS_POL 3
`define TXPMX_POL_DIR_MASK 8'h0b
`endif

// ---- inc/txpmx_pkg.sv ----
// Types of the transmit port selector.
package txpmx_pkg;
  typedef enum logic [3:0] {
    TXPMX_FN_FRAME_SYNC = 4'b0000,
    TXPMX_FN_MF_SYNC = 4'b0001,
    TXPMX_FN_SIG_DATA = 4'b0010,
    TXPMX_FN_TX_CLOCK = 4'b0011,
    TXPMX_FN_MF_BEGIN = 4'b0100,
    TXPMX_FN_SIG_MARKER = 4'b0101,
    TXPMX_FN_SPARE_MARKER = 4'b0110,
    TXPMX_FN_LINE_CLOCK = 4'b0111,
    TXPMX_FN_LINE_TRISTATE = 4'b1000
  } txpmx_func_t;
endpackage

// ---- hw/txpmx_top.sv ----
// Function and direction selector for the four transmit multifunction ports.
//
// Decided for this implementation: strobed register access and the register offsets.
`include "txpmx_map.svh"

module txpmx_top
  import txpmx_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [3:0] tx_port_pin_i,
  output logic [3:0] tx_port_pin_o,
  output logic [3:0] tx_port_oe_o,
  input wire logic tx_multiframe_begin_i,
  input wire logic tx_signaling_marker_i,
  input wire logic tx_spare_bit_marker_i,
  input wire logic tx_line_clock_i,
  input wire logic register_line_tristate_bit_i,
  output logic tx_frame_sync_pulse_in_o,
  output logic tx_multiframe_sync_in_o,
  output logic tx_signaling_data_in_o,
  output logic tx_signaling_data_valid_o,
  output logic tx_clock_in_o,
  output logic tx_line_tristate_o,
  output logic sys_rx_clock_dir_o,
  output logic rx_clock_dir_o
);

  logic [7:0] port_cfg_q [4];
  logic [7:0] pol_dir_q;
  logic [3:0] func_out_d;
  logic [3:0] oe_d;
  logic fs_d;
  logic mfs_d;
  logic sig_d;
  logic clk_d;
  logic line_tri_d;

  // Output functions are 0100 to 0111; 1000 and undefined codes stay inputs.
  function automatic logic txpmx_is_output(input logic [3:0] code);
    return (code[3] == 1'b0) && (code[2] == 1'b1);
  endfunction

  function automatic logic [3:0] txpmx_code(input logic [7:0] cfg);
    return cfg[`TXPMX_FUNC_MSB:0];
  endfunction

  // Register writes; the reserved polarity register bit is forced to zero.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < 4; i++) begin
        port_cfg_q[i] <= `TXPMX_RST_CFG;
      end
    end else if (reg_wr_i) begin
      for (int i = 0; i < 4; i++) begin
        if (reg_addr_i == `TXPMX_OFS_PORT_A + 8'(i)) begin
          port_cfg_q[i] <= reg_wdata_i;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pol_dir_q <= `TXPMX_RST_CFG;
    end else if (reg_wr_i && reg_addr_i == `TXPMX_OFS_POL_DIR) begin
      pol_dir_q <= reg_wdata_i & `TXPMX_POL_DIR_MASK;
    end
  end

  // Read data appears in the cycle after the strobe only; unmapped reads give zero.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `TXPMX_OFS_PORT_A: reg_rdata_o <= port_cfg_q[0];
        `TXPMX_OFS_PORT_B: reg_rdata_o <= port_cfg_q[1];
        `TXPMX_OFS_PORT_C: reg_rdata_o <= port_cfg_q[2];
        `TXPMX_OFS_PORT_D: reg_rdata_o <= port_cfg_q[3];
        `TXPMX_OFS_POL_DIR: reg_rdata_o <= pol_dir_q;
        `TXPMX_OFS_STATUS: reg_rdata_o <= {tx_port_oe_o, tx_port_pin_i};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // Port decode; with duplicate input functions the ports are ORed, which software avoids.
  always_comb begin
    func_out_d = 4'h0;
    oe_d = 4'h0;
    fs_d = 1'b0;
    mfs_d = 1'b0;
    sig_d = 1'b0;
    clk_d = 1'b0;
    line_tri_d = register_line_tristate_bit_i;
    for (int i = 0; i < 4; i++) begin
      oe_d[i] = txpmx_is_output(txpmx_code(port_cfg_q[i]));
      unique case (txpmx_code(port_cfg_q[i]))
        TXPMX_FN_FRAME_SYNC: fs_d = fs_d | tx_port_pin_i[i];
        TXPMX_FN_MF_SYNC: begin
          mfs_d = mfs_d | (tx_port_pin_i[i] ~^ pol_dir_q[`TXPMX_BIT_MFS_POL]);
        end
        TXPMX_FN_SIG_DATA: sig_d = sig_d | tx_port_pin_i[i];
        TXPMX_FN_TX_CLOCK: clk_d = clk_d | tx_port_pin_i[i];
        TXPMX_FN_MF_BEGIN: func_out_d[i] = tx_multiframe_begin_i;
        TXPMX_FN_SIG_MARKER: func_out_d[i] = tx_signaling_marker_i;
        TXPMX_FN_SPARE_MARKER: func_out_d[i] = tx_spare_bit_marker_i;
        TXPMX_FN_LINE_CLOCK: func_out_d[i] = tx_line_clock_i;
        TXPMX_FN_LINE_TRISTATE: line_tri_d = line_tri_d | tx_port_pin_i[i];
        default: func_out_d[i] = 1'b0;
      endcase
    end
  end

  // Outputs are registered, so every path through the selector adds one cycle.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tx_port_pin_o <= 4'h0;
      tx_port_oe_o <= 4'h0;
    end else begin
      tx_port_pin_o <= func_out_d & oe_d;
      tx_port_oe_o <= oe_d;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tx_frame_sync_pulse_in_o <= 1'b0;
      tx_multiframe_sync_in_o <= 1'b0;
      tx_signaling_data_in_o <= 1'b0;
      tx_signaling_data_valid_o <= 1'b0;
      tx_clock_in_o <= 1'b0;
      tx_line_tristate_o <= 1'b0;
    end else begin
      tx_frame_sync_pulse_in_o <= fs_d;
      tx_multiframe_sync_in_o <= mfs_d;
      tx_signaling_data_in_o <= sig_d;
      tx_signaling_data_valid_o <= tx_signaling_marker_i;
      tx_clock_in_o <= clk_d;
      tx_line_tristate_o <= line_tri_d;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sys_rx_clock_dir_o <= 1'b0;
      rx_clock_dir_o <= 1'b0;
    end else begin
      sys_rx_clock_dir_o <= pol_dir_q[`TXPMX_BIT_SYS_RX_CLK_DIR];
      rx_clock_dir_o <= pol_dir_q[`TXPMX_BIT_RX_CLK_DIR];
    end
  end

  AST_RESET_INPUTS: assert property (@(posedge sys_clk_i)
    reset_i |=> tx_port_oe_o == 4'h0)
    else $error("Ports not inputs after reset.");

  AST_OE_FOLLOWS_CODE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    1'b1 |=> tx_port_oe_o[0] == txpmx_is_output(txpmx_code($past(port_cfg_q[0]))))
    else $error("Port A direction does not match its code.");

  AST_HIGH_CODES_IN: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    port_cfg_q[1][3] |=> !tx_port_oe_o[1])
    else $error("Port B driven with a code of 1000 or above.");

  AST_WRITE_PORT_C: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == `TXPMX_OFS_PORT_C |=> port_cfg_q[2] == $past(reg_wdata_i))
    else $error("Port C register not written.");

  AST_TRISTATE_OR: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    register_line_tristate_bit_i |=> tx_line_tristate_o)
    else $error("Register tristate bit ignored.");

  AST_MFS_POL: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    txpmx_code(port_cfg_q[3]) == TXPMX_FN_MF_SYNC && !pol_dir_q[3] && !tx_port_pin_i[3]
      |=> tx_multiframe_sync_in_o)
    else $error("Active low multiframe sync not seen.");

  AST_LINE_CLOCK: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    txpmx_code(port_cfg_q[0]) == TXPMX_FN_LINE_CLOCK |=> tx_port_pin_o[0] == $past(tx_line_clock_i))
    else $error("Line clock not driven on port A.");

  AST_RSVD_ZERO: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    1'b1 |-> !pol_dir_q[`TXPMX_BIT_RSVD])
    else $error("Reserved polarity register bit set.");

  AST_MF_BEGIN: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    txpmx_code(port_cfg_q[2]) == TXPMX_FN_MF_BEGIN && tx_multiframe_begin_i |=> tx_port_pin_o[2])
    else $error("Multiframe begin not driven on port C.");

  // Multi-step behaviours are built from these sequences.
  sequence s_wr_pol;
    reg_wr_i && reg_addr_i == `TXPMX_OFS_POL_DIR;
  endsequence

  sequence s_rd_status;
    reg_rd_i && reg_addr_i == `TXPMX_OFS_STATUS;
  endsequence

  sequence s_park_a;
    reg_wr_i && reg_addr_i == `TXPMX_OFS_PORT_A && reg_wdata_i[3:0] == 4'h4;
  endsequence

  AST_RESET_PINS_LOW: assert property (@(posedge sys_clk_i)
    reset_i |=> tx_port_pin_o == 4'h0)
    else $error("Port pins driven after reset.");

  AST_RESET_CFG_ZERO: assert property (@(posedge sys_clk_i)
    reset_i |=> port_cfg_q[0] == 8'h00 && port_cfg_q[1] == 8'h00
      && port_cfg_q[2] == 8'h00 && port_cfg_q[3] == 8'h00)
    else $error("Port registers not cleared by reset.");

  AST_RESET_DIR_LOW: assert property (@(posedge sys_clk_i)
    reset_i |=> !sys_rx_clock_dir_o && !rx_clock_dir_o)
    else $error("Clock pins not inputs after reset.");

  AST_OE_B: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    1'b1 |=> tx_port_oe_o[1] == txpmx_is_output(txpmx_code($past(port_cfg_q[1]))))
    else $error("Port B direction does not match its code.");

  AST_OE_C: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    1'b1 |=> tx_port_oe_o[2] == txpmx_is_output(txpmx_code($past(port_cfg_q[2]))))
    else $error("Port C direction does not match its code.");

  AST_OE_D: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    1'b1 |=> tx_port_oe_o[3] == txpmx_is_output(txpmx_code($past(port_cfg_q[3]))))
    else $error("Port D direction does not match its code.");

  AST_PIN_ZERO_WHEN_IN: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    1'b1 |-> (tx_port_pin_o & ~tx_port_oe_o) == 4'h0)
    else $error("Undriven port shows a nonzero value.");

  AST_LINE_CLOCK_DRIVES: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    txpmx_code(port_cfg_q[2]) == TXPMX_FN_LINE_CLOCK |=> tx_port_oe_o[2])
    else $error("Output code on port C leaves the pin undriven.");

  AST_PARK_TWO_STEP: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_park_a |=> ##1 tx_port_oe_o[0])
    else $error("Port A not driven two cycles after an output code write.");

  AST_WRITE_PORT_A: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == `TXPMX_OFS_PORT_A |=> port_cfg_q[0] == $past(reg_wdata_i))
    else $error("Port A register not written.");

  AST_WRITE_PORT_B: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == `TXPMX_OFS_PORT_B |=> port_cfg_q[1] == $past(reg_wdata_i))
    else $error("Port B register not written.");

  AST_WRITE_PORT_D: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == `TXPMX_OFS_PORT_D |=> port_cfg_q[3] == $past(reg_wdata_i))
    else $error("Port D register not written.");

  AST_READ_PORT_A: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_rd_i && reg_addr_i == `TXPMX_OFS_PORT_A |=> reg_rdata_o == $past(port_cfg_q[0]))
    else $error("Port A register read back wrong.");

  AST_READ_IDLE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("Read data not zero outside a read.");

  AST_READ_STATUS: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_rd_status |=> reg_rdata_o == {$past(tx_port_oe_o), $past(tx_port_pin_i)})
    else $error("Status byte does not show directions and pins.");

  AST_FRAME_SYNC: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    txpmx_code(port_cfg_q[0]) == TXPMX_FN_FRAME_SYNC && tx_port_pin_i[0]
      |=> tx_frame_sync_pulse_in_o)
    else $error("Frame sync pulse on port A not passed on.");

  AST_FS_IDLE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    txpmx_code(port_cfg_q[0]) != TXPMX_FN_FRAME_SYNC
      && txpmx_code(port_cfg_q[1]) != TXPMX_FN_FRAME_SYNC
      && txpmx_code(port_cfg_q[2]) != TXPMX_FN_FRAME_SYNC
      && txpmx_code(port_cfg_q[3]) != TXPMX_FN_FRAME_SYNC |=> !tx_frame_sync_pulse_in_o)
    else $error("Frame sync seen with no port selecting it.");

  AST_MFS_HIGH: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    txpmx_code(port_cfg_q[1]) == TXPMX_FN_MF_SYNC && pol_dir_q[3] && tx_port_pin_i[1]
      |=> tx_multiframe_sync_in_o)
    else $error("Active high multiframe sync not seen.");

  AST_MFS_HIGH_IDLE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    txpmx_code(port_cfg_q[1]) == TXPMX_FN_MF_SYNC && pol_dir_q[3] && !tx_port_pin_i[1]
      && txpmx_code(port_cfg_q[0]) != TXPMX_FN_MF_SYNC
      && txpmx_code(port_cfg_q[2]) != TXPMX_FN_MF_SYNC
      && txpmx_code(port_cfg_q[3]) != TXPMX_FN_MF_SYNC |=> !tx_multiframe_sync_in_o)
    else $error("Idle active high multiframe sync taken as active.");

  AST_SIG_DATA: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    txpmx_code(port_cfg_q[2]) == TXPMX_FN_SIG_DATA && tx_port_pin_i[2]
      |=> tx_signaling_data_in_o)
    else $error("Signaling data on port C not passed on.");

  AST_SIG_VALID: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    1'b1 |=> tx_signaling_data_valid_o == $past(tx_signaling_marker_i))
    else $error("Signaling data qualifier does not follow the marker.");

  AST_TX_CLOCK: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    txpmx_code(port_cfg_q[3]) == TXPMX_FN_TX_CLOCK && tx_port_pin_i[3] |=> tx_clock_in_o)
    else $error("Transmit clock on port D not passed on.");

  AST_MF_BEGIN_LOW: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    txpmx_code(port_cfg_q[2]) == TXPMX_FN_MF_BEGIN && !tx_multiframe_begin_i
      |=> !tx_port_pin_o[2])
    else $error("Multiframe begin high on port C while idle.");

  AST_SIG_MARKER: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    txpmx_code(port_cfg_q[1]) == TXPMX_FN_SIG_MARKER
      |=> tx_port_pin_o[1] == $past(tx_signaling_marker_i))
    else $error("Signaling marker not driven on port B.");

  AST_SPARE_MARKER: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    txpmx_code(port_cfg_q[3]) == TXPMX_FN_SPARE_MARKER
      |=> tx_port_pin_o[3] == $past(tx_spare_bit_marker_i))
    else $error("Spare bit marker not driven on port D.");

  AST_LINE_TRISTATE_PIN: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    txpmx_code(port_cfg_q[2]) == TXPMX_FN_LINE_TRISTATE && tx_port_pin_i[2]
      |=> tx_line_tristate_o)
    else $error("Tristate pin on port C ignored.");

  AST_TRISTATE_LOW: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !register_line_tristate_bit_i
      && txpmx_code(port_cfg_q[0]) != TXPMX_FN_LINE_TRISTATE
      && txpmx_code(port_cfg_q[1]) != TXPMX_FN_LINE_TRISTATE
      && txpmx_code(port_cfg_q[2]) != TXPMX_FN_LINE_TRISTATE
      && txpmx_code(port_cfg_q[3]) != TXPMX_FN_LINE_TRISTATE |=> !tx_line_tristate_o)
    else $error("Line tristated with no source asking for it.");

  AST_POL_WRITE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_wr_pol |=> pol_dir_q == ($past(reg_wdata_i) & `TXPMX_POL_DIR_MASK))
    else $error("Polarity register write not taken.");

  AST_POL_TWO_STEP: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_wr_pol |=> ##1 sys_rx_clock_dir_o == $past(reg_wdata_i[`TXPMX_BIT_SYS_RX_CLK_DIR], 2))
    else $error("System receive clock direction not set two cycles after a write.");

  AST_RX_DIR: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    1'b1 |=> rx_clock_dir_o == $past(pol_dir_q[`TXPMX_BIT_RX_CLK_DIR]))
    else $error("Receive clock direction does not follow its bit.");

  AST_HIGH_CODES_A: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    port_cfg_q[0][3] |=> !tx_port_oe_o[0])
    else $error("Port A driven with a code of 1000 or above.");

  AST_HIGH_CODES_C: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    port_cfg_q[2][3] |=> !tx_port_oe_o[2])
    else $error("Port C driven with a code of 1000 or above.");

  AST_HIGH_CODES_D: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    port_cfg_q[3][3] |=> !tx_port_oe_o[3])
    else $error("Port D driven with a code of 1000 or above.");

endmodule

// ---- testbench/txpmx_partner.sv ----
// Far-side highway model that drives every transmit port the selector leaves undriven.
module txpmx_partner (
  input wire logic sys_clk_i,
  input wire logic [3:0] tx_port_oe_i,
  input wire logic [3:0] tx_port_drv_i,
  output logic [3:0] tx_port_lvl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] hwy_q = 4'h5;
  // A new random pattern is drawn every cycle, so a stale level matches a live one only by chance.
  always @(posedge sys_clk_i) hwy_q <= 4'($urandom);
  assign tx_port_lvl_o = (tx_port_oe_i & tx_port_drv_i) | (~tx_port_oe_i & hwy_q);
endmodule

// ---- testbench/test_txpmx_top.sv ----
// Random self-checking bench for the transmit port selector.
module test_txpmx_top
  import txpmx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, lt = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, pd;
  logic [3:0] src = 4'h0, pin_lvl, pin_o, oe;
  logic fs, mfs, sig, sigv, tck, tri_o, srx, rxd;
  logic [7:0] cfg [4];
  logic [23:0] exp_v, got;
  int errors = 0, checks = 0;
  txpmx_top i_txpmx_top (.sys_clk_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .tx_port_pin_i(pin_lvl),
    .tx_port_pin_o(pin_o), .tx_port_oe_o(oe), .tx_multiframe_begin_i(src[0]),
    .tx_signaling_marker_i(src[1]), .tx_spare_bit_marker_i(src[2]),
    .tx_line_clock_i(src[3]), .register_line_tristate_bit_i(lt),
    .tx_frame_sync_pulse_in_o(fs), .tx_multiframe_sync_in_o(mfs),
    .tx_signaling_data_in_o(sig), .tx_signaling_data_valid_o(sigv), .tx_clock_in_o(tck),
    .tx_line_tristate_o(tri_o), .sys_rx_clock_dir_o(srx), .rx_clock_dir_o(rxd));
  txpmx_partner i_txpmx_partner (.sys_clk_i(clk), .tx_port_oe_i(oe), .tx_port_drv_i(pin_o),
    .tx_port_lvl_o(pin_lvl));
  assign got = {rdata, pin_o, oe, fs, mfs, sig, sigv, tck, tri_o, srx, rxd};
  initial forever #50 clk = ~clk;
  function automatic logic [23:0] model();
    logic [7:0] rv;
    logic [3:0] en, po, code;
    logic [15:0] hit;
    rv = 8'h00;
    en = 4'h0;
    po = 4'h0;
    hit = 16'h0000;
    if (rd && addr[7:2] == 6'h20) rv = cfg[addr[1:0]];
    if (rd && addr == 8'h84) rv = pd & 8'h0b;
    if (rd && addr == 8'h85) rv = {oe, pin_lvl};
    for (int p = 0; p < 4; p++) begin
      code = cfg[p][3:0];
      en[p] = code inside {[4:7]};
      po[p] = en[p] & src[code[1:0]];
      hit[code] |= (code == 4'h1) ? pin_lvl[p] ^ ~pd[3] : pin_lvl[p];
    end
    return {rv, po, en, hit[0], hit[1], hit[2], src[1], hit[3], hit[8] | lt, pd[1], pd[0]};
  endfunction
  always @(posedge clk) begin
    exp_v <= rst ? 24'h0 : model();
    src <= 4'($urandom);
    lt <= 1'($urandom);
    if (rst) begin
      cfg <= '{default: 8'h00};
      pd <= 8'h00;
    end else if (wr && addr[7:2] == 6'h20) cfg[addr[1:0]] <= wd;
    else if (wr && addr == 8'h84) pd <= wd;
  end
  always @(negedge clk) begin
    if (!rst) begin
      checks++;
      if (got !== exp_v) begin
        errors++;
        $display("Error outputs expected %h seen %h", exp_v, got);
      end
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic stop_test();
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    logic [3:0] c;
    logic [2:0] rot;
    logic [7:0] a;
    logic w;
    void'($urandom(32'hc19d));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int e = 0; e < 60; e++) begin
      rot = 3'($urandom);
      // Parking every port on an output first avoids a moment with a doubled input function.
      for (int p = 0; p < 4; p++) bus(1'b1, 8'h80 + 8'(p), 8'h04);
      for (int p = 0; p < 4; p++) begin
        c = 4'((p + rot[1:0]) % 4);
        if (c == {3'b000, rot[2]}) c = 4'h8;
        if (1'($urandom)) c = 4'(4 + $urandom % 12);
        bus(1'b1, 8'h80 + 8'(p), {4'($urandom), c});
      end
      repeat (8) begin
        w = 1'($urandom);
        a = 1'($urandom) ? 8'h80 + 8'($urandom % 8) : 8'($urandom);
        if (w && a[7:2] == 6'h20) a = 8'h84;
        bus(w, a, 8'($urandom) & 8'hfb);
      end
    end
    stop_test();
  end
endmodule
